// *** chroma_sharp_pkg.sv ***
// Purpose: Shared constants, types and helpers for the chroma edge sharpener.
// Assumes: One pixel per clk_sys edge; chroma is signed two's complement, 8 bits.
// Notes: Range and gain selector codes are shared by the datapath and its checks.
package chroma_sharp_pkg;

    localparam int SAMPLE_W = 8;
    localparam int RANGE_MAX = 12;
    localparam int TAP_CENTER = RANGE_MAX;
    localparam int TAP_COUNT = 2 * RANGE_MAX + 2;
    localparam int SCALE_SHIFT = 4;

    localparam logic [1:0] RANGE_SEL_12 = 2'h0;
    localparam logic [1:0] RANGE_SEL_8 = 2'h1;
    localparam logic [1:0] RANGE_SEL_6 = 2'h2;
    localparam logic [1:0] RANGE_SEL_4 = 2'h3;
    localparam logic [3:0] SPAN_12 = 4'hC;
    localparam logic [3:0] SPAN_8 = 4'h8;
    localparam logic [3:0] SPAN_6 = 4'h6;
    localparam logic [3:0] SPAN_4 = 4'h4;

    localparam logic [1:0] GAIN_SEL_ZERO = 2'h0;
    localparam logic [1:0] GAIN_SEL_QUARTER = 2'h1;
    localparam logic [1:0] GAIN_SEL_HALF = 2'h2;
    localparam logic [1:0] GAIN_SEL_UNITY = 2'h3;
    localparam logic [2:0] GAIN_MUL_ZERO = 3'h0;
    localparam logic [2:0] GAIN_MUL_QUARTER = 3'h1;
    localparam logic [2:0] GAIN_MUL_HALF = 3'h2;
    localparam logic [2:0] GAIN_MUL_UNITY = 3'h4;

    localparam logic [7:0] SAMPLE_RESET = 8'h00;

    typedef logic signed [SAMPLE_W-1:0] sample_t;
    typedef logic signed [SAMPLE_W:0] slope_t;

    // Phase of the 4:1:1 input cycle, Gray coded along the count.
    typedef enum logic [1:0] {
        PH_NEW = 2'b00,
        PH_ONE = 2'b01,
        PH_HOLD = 2'b11,
        PH_THREE = 2'b10
    } phase_t;

    // Midpoint of two samples, rounded toward minus infinity.
    function automatic sample_t mid(input sample_t a, input sample_t b);
        logic signed [SAMPLE_W:0] s;
        s = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
        return s[SAMPLE_W:1];
    endfunction

    // Difference of two samples at full width so it cannot wrap.
    function automatic slope_t slope(input sample_t a, input sample_t b);
        return {a[SAMPLE_W-1], a} - {b[SAMPLE_W-1], b};
    endfunction

    // Magnitude of a slope.
    function automatic logic [SAMPLE_W:0] mag(input slope_t d);
        return d[SAMPLE_W] ? 9'(-d) : 9'(d);
    endfunction

    // Range selector to span in pixels.
    function automatic logic [3:0] range_span(input logic [1:0] sel);
        unique case (sel)
            RANGE_SEL_12: return SPAN_12;
            RANGE_SEL_8: return SPAN_8;
            RANGE_SEL_6: return SPAN_6;
            RANGE_SEL_4: return SPAN_4;
        endcase
    endfunction

    // Gain selector to multiplier in quarters.
    function automatic logic [2:0] gain_mul(input logic [1:0] sel);
        unique case (sel)
            GAIN_SEL_ZERO: return GAIN_MUL_ZERO;
            GAIN_SEL_QUARTER: return GAIN_MUL_QUARTER;
            GAIN_SEL_HALF: return GAIN_MUL_HALF;
            GAIN_SEL_UNITY: return GAIN_MUL_UNITY;
        endcase
    endfunction

endpackage

// *** chroma_stream_if.sv ***
// Purpose: Carries the 4:2:2 chroma stream from the upsampler to the edge stage.
// Assumes: One clock domain.
// Notes: step pulses when a new 4:2:2 pair is presented.
`timescale 1ns/1ps
interface chroma_stream_if;
    import chroma_sharp_pkg::*;
    sample_t u;
    sample_t v;
    logic step;
    modport source (output u, output v, output step);
    modport sink (input u, input v, input step);
endinterface

// *** chroma_upsampler.sv ***
// Purpose: Two to one linear interpolation of 4:1:1 chroma into 4:2:2.
// Assumes: uv_strobe marks a new 4:1:1 pair and repeats every fourth clock.
// Notes: A strobe always restarts the phase, so a late strobe resynchronises cleanly.
`timescale 1ns/1ps
module chroma_upsampler (
    input wire logic clk_sys, // Pixel clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire chroma_sharp_pkg::sample_t u_in, // 4:1:1 U sample.
    input wire chroma_sharp_pkg::sample_t v_in, // 4:1:1 V sample.
    input wire logic uv_strobe, // New 4:1:1 pair present.
    chroma_stream_if.source out // 4:2:2 stream.
);
    import chroma_sharp_pkg::*;

    sample_t cur_u;
    sample_t cur_v;
    phase_t phase;

    // Phase counter restarted by each input strobe.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase <= PH_NEW;
        end else if (uv_strobe) begin
            phase <= PH_ONE;
        end else begin
            unique case (phase)
                PH_NEW: phase <= PH_ONE;
                PH_ONE: phase <= PH_HOLD;
                PH_HOLD: phase <= PH_THREE;
                PH_THREE: phase <= PH_NEW;
            endcase
        end
    end

    // Latest 4:1:1 pair, kept for the hold half of the cycle.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur_u <= SAMPLE_RESET;
            cur_v <= SAMPLE_RESET;
        end else if (uv_strobe) begin
            cur_u <= u_in;
            cur_v <= v_in;
        end
    end

    // midpoint then sample
    // The midpoint goes out first so the original sample lands on its own grid slot.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            out.u <= SAMPLE_RESET;
            out.v <= SAMPLE_RESET;
            out.step <= 1'b0;
        end else if (uv_strobe) begin
            out.u <= mid(cur_u, u_in);
            out.v <= mid(cur_v, v_in);
            out.step <= 1'b1;
        end else if (phase == PH_HOLD) begin
            out.u <= cur_u;
            out.v <= cur_v;
            out.step <= 1'b1;
        end else begin
            out.step <= 1'b0;
        end
    end

    chk_mid_value: assert property (@(posedge clk_sys) disable iff (!nrst)
        uv_strobe |=> (out.u == mid($past(cur_u), $past(u_in)) && out.step))
        else $error("Upsampler midpoint wrong.");

    chk_hold_sample: assert property (@(posedge clk_sys) disable iff (!nrst)
        uv_strobe ##1 !uv_strobe [*2] |=> (out.u == $past(u_in, 3) && out.v == $past(v_in, 3) && out.step))
        else $error("Upsampler hold sample wrong.");

endmodule // chroma_upsampler

// *** chroma_transient_improver.sv ***
// Purpose: Chroma transient improvement: 4:1:1 in, edge-steepened 4:4:4 out.
// Assumes: One pixel per clock; settings are static or change between lines.
// Notes: Output lags the input by TAP_CENTER pixels plus three register stages.
`timescale 1ns/1ps
module chroma_transient_improver (
    input wire logic clk_sys, // Pixel clock, 40 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire chroma_sharp_pkg::sample_t u_in, // 4:1:1 U sample, signed.
    input wire chroma_sharp_pkg::sample_t v_in, // 4:1:1 V sample, signed.
    input wire logic uv_strobe, // New 4:1:1 pair, every fourth clock.
    input wire logic [1:0] range_sel, // Span: 0=12, 1=8, 2=6, 3=4 pixels.
    input wire logic [1:0] gain_sel, // Gain: 0, 1/4, 1/2, 1.
    input wire logic hill_protect_en, // Slope-sign delay limiting on.
    output chroma_sharp_pkg::sample_t u_out, // 4:4:4 U sample, registered.
    output chroma_sharp_pkg::sample_t v_out // 4:4:4 V sample, registered.
);
    import chroma_sharp_pkg::*;

    chroma_stream_if s422 ();

    sample_t hist_u [TAP_COUNT];
    sample_t hist_v [TAP_COUNT];
    logic [TAP_COUNT-1:0] mark;
    logic sign_u_prev;
    logic sign_v_prev;
    logic [SAMPLE_W+1:0] act_prev;
    logic [SAMPLE_W+1:0] act_dly;

    slope_t in_du;
    slope_t in_dv;
    slope_t ctr_du;
    slope_t ctr_dv;
    logic [SAMPLE_W+1:0] act;
    logic signed [SAMPLE_W+2:0] act_rate;
    logic signed [14:0] scaled;
    logic [3:0] span;
    logic [3:0] lim_old;
    logic [3:0] lim_new;
    logic signed [5:0] shift;
    sample_t pick_u;
    sample_t pick_v;

    chroma_upsampler upsampler (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .u_in(u_in),
        .v_in(v_in),
        .uv_strobe(uv_strobe),
        .out(s422.source)
    );

    // pixel-rate history
    // The 4:2:2 value is held for two pixels; index 0 is newest, higher is older.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < TAP_COUNT; i++) begin
                hist_u[i] <= SAMPLE_RESET;
                hist_v[i] <= SAMPLE_RESET;
            end
        end else begin
            hist_u[0] <= s422.u;
            hist_v[0] <= s422.v;
            for (int i = 1; i < TAP_COUNT; i++) begin
                hist_u[i] <= hist_u[i-1];
                hist_v[i] <= hist_v[i-1];
            end
        end
    end

    // Entry slopes span one 4:2:2 step; the centre slope spans three pixels centred one pixel ahead of the output pair,
    // so the activity peak sits on the middle of an edge and not at its two ends.
    assign in_du = slope(hist_u[0], hist_u[2]);
    assign in_dv = slope(hist_v[0], hist_v[2]);
    assign ctr_du = slope(hist_u[TAP_CENTER-2], hist_u[TAP_CENTER+1]);
    assign ctr_dv = slope(hist_v[TAP_CENTER-2], hist_v[TAP_CENTER+1]);

    // slope sign marks
    // Marks travel with the samples so the window sees every turning point.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mark <= '0;
            sign_u_prev <= 1'b0;
            sign_v_prev <= 1'b0;
        end else begin
            sign_u_prev <= in_du[SAMPLE_W];
            sign_v_prev <= in_dv[SAMPLE_W];
            mark <= {mark[TAP_COUNT-2:0], (in_du[SAMPLE_W] != sign_u_prev) || (in_dv[SAMPLE_W] != sign_v_prev)};
        end
    end

    // rate of edge activity
    // Activity is the summed slope magnitude one pixel ahead of the output pair; it is compared with
    // its value two pixels back, a centred difference. A one-sided difference stays zero along a
    // linear ramp, so the edge would pass with no shift and no steepening.
    assign act = {1'b0, mag(ctr_du)} + {1'b0, mag(ctr_dv)};
    assign act_rate = $signed({1'b0, act}) - $signed({1'b0, act_prev});

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            act_dly <= '0;
            act_prev <= '0;
        end else begin
            act_dly <= act;
            act_prev <= act_dly;
        end
    end

    // gain scaling
    // The multiplier is in quarters, so unity is four and the shift absorbs it.
    assign scaled = 15'(($signed({act_rate[SAMPLE_W+2], act_rate}) * $signed({1'b0, gain_mul(gain_sel)})) >>> SCALE_SHIFT);

    assign span = range_span(range_sel);

    // limiter switch
    // Nearest mark on each side caps the shift so a close second edge is not fetched.
    // Marks come from the entry slope, so they sit a little older than their tap and the cap is loose.
    always_comb begin
        lim_old = span;
        lim_new = span;
        if (hill_protect_en) begin
            for (int i = RANGE_MAX; i >= 1; i--) begin
                if (4'(i) <= span && mark[TAP_CENTER+i]) begin
                    lim_old = 4'(i - 1);
                end
                if (4'(i) <= span && mark[TAP_CENTER-i]) begin
                    lim_new = 4'(i - 1);
                end
            end
        end
    end

    // edge half shift
    // Rising activity reaches older samples (more delay), falling reaches newer ones.
    always_comb begin
        if (scaled > $signed({11'h000, lim_old})) begin
            shift = $signed({2'b00, lim_old});
        end else if (scaled < -$signed({11'h000, lim_new})) begin
            shift = -$signed({2'b00, lim_new});
        end else begin
            shift = scaled[5:0];
        end
    end

    // half-pixel interpolation
    // At zero shift this is the plain two to one interpolation about the centre.
    always_comb begin
        int idx;
        idx = TAP_CENTER + int'(shift);
        pick_u = mid(hist_u[idx], hist_u[idx+1]);
        pick_v = mid(hist_v[idx], hist_v[idx+1]);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            u_out <= SAMPLE_RESET;
            v_out <= SAMPLE_RESET;
        end else begin
            u_out <= pick_u;
            v_out <= pick_v;
        end
    end

    chk_zero_gain: assert property (@(posedge clk_sys) disable iff (!nrst)
        (gain_sel == GAIN_SEL_ZERO) |=> (u_out == mid($past(hist_u[TAP_CENTER]), $past(hist_u[TAP_CENTER+1]))))
        else $error("Zero gain is not a plain interpolation.");

    chk_span_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
        (shift <= $signed({2'b00, range_span(range_sel)})) && (shift >= -$signed({2'b00, range_span(range_sel)})))
        else $error("Shift outside selected span.");

    chk_rise_older: assert property (@(posedge clk_sys) disable iff (!nrst)
        (act > act_prev) && (gain_sel == GAIN_SEL_UNITY) && !hill_protect_en && (act - act_prev >= 10'd16) |-> shift > 0)
        else $error("Rising edge half did not lengthen the delay.");

    chk_fall_newer: assert property (@(posedge clk_sys) disable iff (!nrst)
        (act < act_prev) |-> shift <= 0)
        else $error("Falling edge half lengthened the delay.");

    chk_flat_nominal: assert property (@(posedge clk_sys) disable iff (!nrst)
        (act == act_prev) |-> (shift == 0) ##1 (v_out == mid($past(hist_v[TAP_CENTER]), $past(hist_v[TAP_CENTER+1]))))
        else $error("Flat picture did not take the nominal delay.");

    chk_hill_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
        hill_protect_en && mark[TAP_CENTER+1] |-> shift <= 0)
        else $error("Shift crossed a slope sign change.");

    chk_hill_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        !hill_protect_en && (scaled >= 0) && (scaled <= $signed({11'h000, range_span(range_sel)})) |-> shift == scaled[5:0])
        else $error("Limiter acted while switched off.");

    chk_gain_unity: assert property (@(posedge clk_sys) disable iff (!nrst)
        (gain_sel == GAIN_SEL_UNITY) && (act_rate == 11'sd64) && !hill_protect_en && (range_sel == RANGE_SEL_12)
        |-> shift == 6'sd12)
        else $error("Unity gain scaling wrong.");

    // Each gain and span case below is reached by a plain step between two flat levels.
    chk_gain_quarter: assert property (@(posedge clk_sys) disable iff (!nrst)
        (gain_sel == GAIN_SEL_QUARTER) && (act_rate == 11'sd64) && !hill_protect_en && (range_sel == RANGE_SEL_8)
        |-> shift == 6'sd4)
        else $error("Quarter gain scaling wrong.");

    chk_gain_half: assert property (@(posedge clk_sys) disable iff (!nrst)
        (gain_sel == GAIN_SEL_HALF) && (act_rate == -11'sd64) && !hill_protect_en && (range_sel == RANGE_SEL_8)
        |-> shift == -6'sd8)
        else $error("Half gain scaling wrong.");

    chk_span_four: assert property (@(posedge clk_sys) disable iff (!nrst)
        (range_sel == RANGE_SEL_4) && (gain_sel == GAIN_SEL_UNITY) && !hill_protect_en && (act_rate == 11'sd64)
        |-> shift == 6'sd4)
        else $error("Four pixel span not applied.");

    chk_hill_newer: assert property (@(posedge clk_sys) disable iff (!nrst)
        hill_protect_en && mark[TAP_CENTER-1] |-> shift >= 0)
        else $error("Shift crossed a newer slope sign change.");

    chk_step_cadence: assert property (@(posedge clk_sys) disable iff (!nrst)
        s422.step |=> !s422.step ##1 s422.step)
        else $error("Upsampled pairs not presented every second pixel.");

endmodule // chroma_transient_improver

// *** chroma_source_model.sv ***
// Purpose: Model of the chroma input path that feeds 4:1:1 pairs.
// Assumes: One pair every fourth clock, driven at the falling edge.
// Notes: Between strobes the lines carry no valid data.
`timescale 1ns/1ps
module chroma_source_model (
    input wire logic clk_sys, // Pixel clock.
    input wire logic nrst, // Reset, active low.
    input wire chroma_sharp_pkg::sample_t tgt_u, // U to send next.
    input wire chroma_sharp_pkg::sample_t tgt_v, // V to send next.
    output chroma_sharp_pkg::sample_t u_in, // 4:1:1 U.
    output chroma_sharp_pkg::sample_t v_in, // 4:1:1 V.
    output logic uv_strobe // New pair.
);
    import chroma_sharp_pkg::*;
    logic [1:0] ph;
    logic send_now;
    assign send_now = nrst && ph == 2'h3;
    // Known values at time zero.
    initial begin
        ph = 2'h0;
        u_in = 8'h00;
        v_in = 8'h00;
        uv_strobe = 1'b0;
    end
    // Invalid lines toggle, so a capture off the strobe cannot look right by chance.
    always @(negedge clk_sys) begin
        uv_strobe <= send_now;
        u_in <= send_now ? tgt_u : ~u_in;
        v_in <= send_now ? tgt_v : ~v_in;
        ph <= nrst ? ph + 2'h1 : 2'h0;
    end
endmodule // chroma_source_model

// *** tb.sv ***
// Purpose: Self-checking bench for the chroma transient improver.
// Assumes: Settings change only while the input is flat.
// Notes: Edges are judged by counting in-between samples, so latency need not be exact.
`timescale 1ns/1ps
module tb;
    import chroma_sharp_pkg::*;
    logic clk_sys;
    logic nrst;
    logic [1:0] range_sel;
    logic [1:0] gain_sel;
    logic hill_protect_en;
    logic uv_strobe;
    logic mon_on;
    sample_t tgt_u, tgt_v, u_in, v_in, u_out, v_out, prev_u;
    int num_errors, n_tests, n_mid, n_turn, n_out, dir;

    // Pixel clock at 40 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    chroma_source_model i_chroma_source_model (.clk_sys(clk_sys), .nrst(nrst), .tgt_u(tgt_u),
        .tgt_v(tgt_v), .u_in(u_in), .v_in(v_in), .uv_strobe(uv_strobe));
    chroma_transient_improver i_chroma_transient_improver (.clk_sys(clk_sys), .nrst(nrst),
        .u_in(u_in), .v_in(v_in), .uv_strobe(uv_strobe), .range_sel(range_sel),
        .gain_sel(gain_sel), .hill_protect_en(hill_protect_en), .u_out(u_out), .v_out(v_out));

    // Shape of u_out between levels 00 and 40, sampled where outputs are settled.
    always @(negedge clk_sys) begin
        if (mon_on) begin
            if (u_out > 8'sh00 && u_out < 8'sh40) n_mid++;
            if (u_out < 8'sh00 || u_out > 8'sh40) n_out++;
            if (u_out > prev_u) begin
                if (dir < 0) n_turn++;
                dir = 1;
            end else if (u_out < prev_u) begin
                if (dir > 0) n_turn++;
                dir = -1;
            end
        end
        prev_u = u_out;
    end

    task automatic chk_s(input sample_t got, input sample_t exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got);
        n_tests++;
        if (got !== 1'b1) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=1", $time, got);
        end
    endtask

    // V always mirrors U with the opposite sign.
    task automatic send(input sample_t a, input int strobes);
        tgt_u <= a;
        tgt_v <= -a;
        repeat (4 * strobes) @(negedge clk_sys);
    endtask

    // Flat zero, then a step to 40 held for width pairs, then back to zero when short.
    task automatic shape(input logic [1:0] g, input logic [1:0] r, input logic p, input int width);
        gain_sel <= g;
        range_sel <= r;
        hill_protect_en <= p;
        send(8'h00, 10);
        n_mid = 0;
        n_turn = 0;
        n_out = 0;
        dir = 0;
        mon_on <= 1'b1;
        send(8'h40, width);
        if (width < 10) send(8'h00, 10);
        mon_on <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic test_flat();
        gain_sel <= GAIN_SEL_UNITY;
        send(8'h35, 10);
        chk_s(u_out, 8'h35);
        chk_s(v_out, 8'hCB);
        $display("test_flat done");
    endtask

    task automatic test_plain();
        // A 00 to 40 step in 4:1:1 gives exactly 10, 20 and 30 once each at zero gain.
        shape(GAIN_SEL_ZERO, RANGE_SEL_12, 1'b0, 10);
        chk_b(n_mid == 3);
        chk_b(n_turn == 0);
        chk_s(u_out, 8'h40);
        chk_s(v_out, 8'hC0);
        $display("test_plain done");
    endtask

    task automatic test_steep();
        for (int r = 0; r < 4; r++) begin
            shape(GAIN_SEL_UNITY, 2'(r), 1'b0, 10);
            chk_b(n_mid < 3);
            chk_b(n_out == 0);
            chk_s(u_out, 8'h40);
        end
        for (int g = 1; g < 3; g++) begin
            shape(2'(g), RANGE_SEL_8, 1'b0, 10);
            chk_b(n_mid <= 3 && n_out == 0);
            chk_s(v_out, 8'hC0);
        end
        $display("test_steep done");
    endtask

    task automatic test_hill();
        shape(GAIN_SEL_ZERO, RANGE_SEL_12, 1'b1, 3);
        chk_b(n_turn == 1);
        shape(GAIN_SEL_UNITY, RANGE_SEL_12, 1'b1, 3);
        chk_b(n_turn <= 1 && n_out == 0);
        shape(GAIN_SEL_UNITY, RANGE_SEL_12, 1'b0, 3);
        chk_b(n_out == 0);
        chk_s(u_out, 8'h00);
        $display("test_hill done");
    endtask

    task automatic test_reset();
        send(8'h50, 10);
        nrst <= 1'b0;
        @(negedge clk_sys);
        chk_s(u_out, 8'h00);
        chk_s(v_out, 8'h00);
        repeat (5) @(negedge clk_sys);
        nrst <= 1'b1;
        send(8'h50, 10);
        chk_s(u_out, 8'h50);
        $display("test_reset done");
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // A hang is cut short well past the expected run of about 980 clocks.
    initial begin
        #150000;
        num_errors++;
        conclude();
    end

    initial begin
        nrst = 1'b0;
        range_sel = RANGE_SEL_12;
        gain_sel = GAIN_SEL_ZERO;
        hill_protect_en = 1'b0;
        tgt_u = 8'h00;
        tgt_v = 8'h00;
        mon_on = 1'b0;
        prev_u = 8'h00;
        num_errors = 0;
        n_tests = 0;
        repeat (6) @(negedge clk_sys);
        nrst <= 1'b1;
        test_flat();
        test_plain();
        test_steep();
        test_hill();
        test_reset();
        conclude();
    end
endmodule // tb
